// ===== src/sbt_pkg.sv
`default_nettype none
package sbt_pkg;
  // Core clock and derived one-second prescale.
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;
  // Command codes.
  localparam logic [7:0] CMD_STANDBY = 8'hE2;
  localparam logic [7:0] CMD_STANDBY_ALT = 8'h96;
  // Timeout code table boundaries and special codes.
  localparam logic [7:0] CODE_OFF = 8'h00;
  localparam logic [7:0] CODE_5S_MAX = 8'hF0;
  localparam logic [7:0] CODE_30M_MAX = 8'hFB;
  localparam logic [7:0] CODE_21M = 8'hFC;
  localparam logic [7:0] CODE_8H = 8'hFD;
  localparam logic [7:0] CODE_ABORT = 8'hFE;
  localparam logic [7:0] CODE_21M15S = 8'hFF;
  // Timeout units and fixed intervals, in seconds.
  localparam int unsigned UNIT_5S = 5;
  localparam int unsigned UNIT_30M = 1800;
  localparam int unsigned FIXED_21M = 1260;
  localparam int unsigned FIXED_8H = 28800;
  localparam int unsigned FIXED_21M15S = 1275;
  localparam int unsigned SEC_W = 16;
  // Drive power states.
  typedef enum logic [1:0] {
    SBT_ACTIVE,
    SBT_SPINDOWN,
    SBT_STANDBY,
    SBT_SPINUP
  } sbt_state_e;
endpackage
`default_nettype wire

// ===== src/sbt_sec_timer.sv
`default_nettype none
// Seconds counter with a one-second prescaler.
module sbt_sec_timer
  import sbt_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input wire logic clk_i, // Core clock.
  input wire logic reset_n_i, // Synchronous reset, active low.
  input wire logic load_i, // Reload the full interval.
  input wire logic [SEC_W-1:0] secs_i, // Interval in seconds.
  input wire logic run_i, // Count while high.
  output logic expire_o // One-cycle pulse at zero.
);
  logic [25:0] pre_reg;
  logic [SEC_W-1:0] sec_reg;
  logic tick;
  // The tick fires once per second of run time only.
  assign tick = run_i && (pre_reg == 26'(TICK_LEN - 1));

  // Prescaler restarts on reload so every interval is whole seconds.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || load_i || !run_i) begin
      pre_reg <= 26'h0;
    end else if (tick) begin
      pre_reg <= 26'h0;
    end else begin
      pre_reg <= pre_reg + 26'h1;
    end
  end

  // Seconds counter; the expiry pulse is registered.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sec_reg <= '0;
      expire_o <= 1'b0;
    end else begin
      expire_o <= 1'b0;
      if (load_i) begin
        sec_reg <= secs_i;
      end else if (tick && sec_reg != '0) begin
        sec_reg <= sec_reg - 1'b1;
        expire_o <= (sec_reg == SEC_W'(1));
      end
    end
  end
endmodule
`default_nettype wire

// ===== src/sbt_standby_timer.sv
`default_nettype none
module sbt_standby_timer
  import sbt_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input wire logic clk_i, // Core clock, 50 MHz.
  input wire logic reset_n_i, // Synchronous reset, active low.
  input wire logic cmd_valid_i, // Command strobe, one cycle.
  input wire logic [7:0] cmd_code_i, // Command register value.
  input wire logic [7:0] sect_cnt_i, // Sector Count timeout code.
  input wire logic access_i, // Host drive access pulse.
  input wire logic media_req_i, // Access needs the media.
  input wire logic epc_en_i, // Extended power conditions on.
  input wire logic spin_at_speed_i, // Spindle at operating speed.
  input wire logic spin_stopped_i, // Spindle fully stopped.
  output logic cmd_done_o, // Standby command complete pulse.
  output logic cmd_abort_o, // Standby command aborted pulse.
  output logic media_ready_o, // Media access may complete.
  output logic spin_on_o, // Spindle motor enable.
  output logic standby_o, // Drive in standby.
  output logic deep_standby_o, // Deepest standby condition.
  output logic timer_en_o, // Automatic power-down enabled.
  output logic auto_standby_o // Pulse on timer-driven standby.
);
  // Power state and the settings captured from the last accepted command.
  // The captured settings survive every state change; only a new accepted
  // command or a reset replaces them.
  sbt_state_e state_reg, state_next;
  logic [SEC_W-1:0] secs_reg;
  logic en_reg;
  logic deep_reg;

  // Decoded timeout and the intermediate values of the code table.
  logic [SEC_W-1:0] dec_secs;
  logic [SEC_W-1:0] code_w;
  logic [SEC_W-1:0] secs_5s;
  logic [SEC_W-1:0] secs_30m;
  logic code_is_off;
  logic code_in_5s;
  logic code_in_30m;
  logic code_is_21m;
  logic code_is_8h;
  logic code_is_abort;

  // Command decode and control of the seconds counter.
  logic is_standby_cmd;
  logic cmd_ok;
  logic cmd_bad;
  logic expire;
  logic load;
  logic run;
  logic go_down;
  logic media_wake;
  logic [SEC_W-1:0] load_secs;

  // Decode of the current and the next power state.
  logic in_active;
  logic next_active;
  logic next_spinup;
  logic next_spindown;
  logic next_standby;
  logic down_target_stop;

  // Next values of the registered outputs.
  logic done_next;
  logic abort_next;
  logic auto_next;
  logic spin_on_next;
  logic standby_next;
  logic deep_sel;
  logic deep_next;
  logic media_ready_next;

  // The code is widened once so that no product below is taken narrower than the
  // counter width.  The largest product, eleven half hours, still fits in
  // the counter, so the casts below never throw away a significant bit.
  assign code_w = SEC_W'(sect_cnt_i);

  // Range flags of the timeout code table.  The two stepped ranges are
  // bounded by compares; the codes above them are single special values
  // and each but 255, which takes the last arm, is matched on its own.
  assign code_is_off = (sect_cnt_i == CODE_OFF);
  assign code_in_5s = !code_is_off &&
    (sect_cnt_i <= CODE_5S_MAX);
  assign code_in_30m = (sect_cnt_i > CODE_5S_MAX) &&
    (sect_cnt_i <= CODE_30M_MAX);
  assign code_is_21m = (sect_cnt_i == CODE_21M);
  assign code_is_8h = (sect_cnt_i == CODE_8H);
  assign code_is_abort = (sect_cnt_i == CODE_ABORT);

  // Products for the two stepped ranges, cut to the counter width.
  // The half-hour range counts from the first code above the 5 s range.
  assign secs_5s = SEC_W'(code_w * UNIT_5S);
  assign secs_30m =
    SEC_W'((code_w - SEC_W'(CODE_5S_MAX)) * UNIT_30M);

  // Select the interval in seconds.  Code 254 falls to the last arm, but
  // it can never reach the stored interval because its command is
  // refused before anything is captured.
  assign dec_secs =
    code_is_off ? '0 :
    code_in_5s ? secs_5s :
    code_in_30m ? secs_30m :
    code_is_21m ? SEC_W'(FIXED_21M) :
    code_is_8h ? SEC_W'(FIXED_8H) :
    SEC_W'(FIXED_21M15S);

  // Command decode.  Both command codes mean the same thing.  Code 254
  // aborts the command and leaves every stored setting as it was; other
  // command codes are not ours and are ignored here.
  assign is_standby_cmd = cmd_valid_i &&
    (cmd_code_i == CMD_STANDBY || cmd_code_i == CMD_STANDBY_ALT);
  assign cmd_bad = is_standby_cmd && code_is_abort;
  assign cmd_ok = is_standby_cmd && !code_is_abort;

  // Store interval, enable and deep-standby choice from an accepted
  // command.  The extended power conditions input is sampled only with such a command,
  // so a later change of that level takes effect with the next command.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      secs_reg <= '0;
      en_reg <= 1'b0;
      deep_reg <= 1'b0;
    end else if (cmd_ok) begin
      secs_reg <= dec_secs;
      en_reg <= !code_is_off;
      deep_reg <= epc_en_i;
    end
  end

  // The timer counts only in the active state with the spindle at speed,
  // so the time spent spinning up never shortens the interval.  Any host
  // access reloads the whole interval, even while the drive is down, so
  // that the count starts fresh when the drive is back to idle.
  assign in_active = (state_reg == SBT_ACTIVE);
  assign run = en_reg && in_active && spin_at_speed_i;
  assign load = cmd_ok || access_i;
  assign load_secs = cmd_ok ? dec_secs : secs_reg;

  // Prescaler and seconds counter.  The expiry pulse comes one cycle
  // after the last second has been counted off.
  sbt_sec_timer #(
    .TICK_LEN(TICK_LEN)
  ) u_sec_timer (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .load_i(load),
    .secs_i(load_secs),
    .run_i(run),
    .expire_o(expire)
  );

  // Reasons to go down: an accepted command, or an expiry that no access
  // in the same cycle has cancelled.  An access in that cycle wins, since
  // it reloads the interval and the drive is plainly in use.
  assign go_down = cmd_ok || (expire && !access_i);
  assign media_wake = access_i && media_req_i;

  // A stopped spindle goes straight to standby without a spin-down.
  assign down_target_stop = spin_stopped_i;

  // Power state sequencing.  A Standby command wins over a media access
  // in the same cycle and takes effect in every state, so the drive heads
  // down at once even while it is still spinning up.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SBT_ACTIVE: begin
        if (go_down) begin
          state_next = down_target_stop ? SBT_STANDBY : SBT_SPINDOWN;
        end
      end
      SBT_SPINDOWN: begin
        if (cmd_ok) begin
          state_next = down_target_stop ? SBT_STANDBY : SBT_SPINDOWN;
        end else if (media_wake) begin
          state_next = SBT_SPINUP;
        end else if (spin_stopped_i) begin
          state_next = SBT_STANDBY;
        end
      end
      SBT_STANDBY: begin
        if (cmd_ok) begin
          state_next = SBT_STANDBY;
        end else if (media_wake) begin
          state_next = SBT_SPINUP;
        end
      end
      SBT_SPINUP: begin
        if (cmd_ok) begin
          state_next = down_target_stop ? SBT_STANDBY : SBT_SPINDOWN;
        end else if (spin_at_speed_i) begin
          state_next = SBT_ACTIVE;
        end
      end
    endcase
  end

  // State register; reset leaves the drive active with the timer off.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_reg <= SBT_ACTIVE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Decode of the next state, shared by the output logic below.  The
  // outputs follow the next state so that they change on the same edge
  // as the state itself and never lag it by a cycle.
  assign next_active = (state_next == SBT_ACTIVE);
  assign next_spinup = (state_next == SBT_SPINUP);
  assign next_spindown = (state_next == SBT_SPINDOWN);
  assign next_standby = (state_next == SBT_STANDBY);

  // Command answers and the timer-driven standby pulse.
  assign done_next = cmd_ok;
  assign abort_next = cmd_bad;
  assign auto_next = expire && !access_i && in_active;

  // The motor is driven while active or spinning up and released in
  // spin-down and standby; the host side keeps working throughout.
  assign spin_on_next = next_active || next_spinup;
  assign standby_next = next_standby || next_spindown;

  // The deepest condition uses the choice of the command being taken, if
  // there is one, so that it is right from the first standby cycle.
  assign deep_sel = cmd_ok ? epc_en_i : deep_reg;
  assign deep_next = deep_sel && next_standby;

  // Media work may finish only with the spindle at operating speed.
  assign media_ready_next = next_active && spin_at_speed_i;

  // Registered outputs; the command interface is never blocked.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cmd_done_o <= 1'b0;
      cmd_abort_o <= 1'b0;
      auto_standby_o <= 1'b0;
      spin_on_o <= 1'b1;
      standby_o <= 1'b0;
      deep_standby_o <= 1'b0;
      media_ready_o <= 1'b0;
    end else begin
      cmd_done_o <= done_next;
      cmd_abort_o <= abort_next;
      auto_standby_o <= auto_next;
      spin_on_o <= spin_on_next;
      standby_o <= standby_next;
      deep_standby_o <= deep_next;
      media_ready_o <= media_ready_next;
    end
  end

  // The enable is a plain register, so it needs no extra flip-flop here.
  // It reads high from the cycle after an accepted command with a nonzero code.
  assign timer_en_o = en_reg;
endmodule
`default_nettype wire

// ===== tb/sbt_standby_timer_sva.sv
`default_nettype none
module sbt_standby_timer_sva
  import sbt_pkg::*;
(
  input wire logic clk_i, // Core clock.
  input wire logic reset_n_i, // Reset, active low.
  input wire logic cmd_valid_i, // Command strobe.
  input wire logic [7:0] cmd_code_i, // Command code.
  input wire logic [7:0] sect_cnt_i, // Timeout code.
  input wire logic spin_at_speed_i, // At speed.
  input wire logic cmd_done_o, // Done pulse.
  input wire logic cmd_abort_o, // Abort pulse.
  input wire logic media_ready_o, // Media ready.
  input wire logic spin_on_o, // Motor enable.
  input wire logic standby_o, // In standby.
  input wire logic deep_standby_o, // Deepest standby.
  input wire logic timer_en_o, // Timer enabled.
  input wire logic auto_standby_o // Timer expiry pulse.
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // A Standby command, taken or refused, under either of its two codes.
  wire logic sb_cmd = cmd_valid_i && (cmd_code_i == CMD_STANDBY ||
    cmd_code_i == CMD_STANDBY_ALT);
  wire logic sb_ok = sb_cmd && sect_cnt_i != CODE_ABORT;
  cmd_done_a: assert property (sb_ok |=> cmd_done_o)
    else $error("standby command not completed");
  cmd_abort_a: assert property (sb_cmd && sect_cnt_i == CODE_ABORT
    |=> cmd_abort_o && !cmd_done_o)
    else $error("code 254 not aborted");
  spin_stop_a: assert property (cmd_done_o |-> !spin_on_o && standby_o)
    else $error("spindle not stopped by standby");
  media_wait_a: assert property (media_ready_o |-> spin_at_speed_i)
    else $error("media ready before spindle at speed");
  timer_off_a: assert property (sb_ok && sect_cnt_i == CODE_OFF
    |=> !timer_en_o)
    else $error("code zero left timer on");
  timer_on_a: assert property (sb_ok && sect_cnt_i != CODE_OFF
    |=> timer_en_o)
    else $error("nonzero code left timer off");
  auto_sleep_a: assert property (auto_standby_o |-> $past(timer_en_o)
    ##[0:1] !spin_on_o)
    else $error("auto standby wrong");
  idle_count_a: assert property (auto_standby_o
    |-> $past(spin_at_speed_i))
    else $error("timer ran while not idle");
  deep_mode_a: assert property (deep_standby_o |-> standby_o)
    else $error("deep standby outside standby");
  // Main scenarios seen.
  cover property (cmd_abort_o);
  cover property (auto_standby_o);
  cover property (deep_standby_o);
endmodule
bind sbt_standby_timer sbt_standby_timer_sva sva_i (.clk_i, .reset_n_i,
  .cmd_valid_i, .cmd_code_i, .sect_cnt_i, .spin_at_speed_i, .cmd_done_o,
  .cmd_abort_o, .media_ready_o, .spin_on_o, .standby_o, .deep_standby_o,
  .timer_en_o, .auto_standby_o);
`default_nettype wire

// ===== tb/sbt_motor.sv
`default_nettype none
module sbt_motor (
  input wire logic clk_i, // Core clock.
  input wire logic spin_on_i, // Motor enable.
  output logic at_speed_o, // At operating speed.
  output logic stopped_o // Fully stopped.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ramp_reg = 2'h0;
  // Ramping takes three cycles each way, so no level answers at once.
  always_ff @(negedge clk_i) begin
    if (spin_on_i && ramp_reg != 2'h3) ramp_reg <= ramp_reg + 2'h1;
    else if (!spin_on_i && ramp_reg != 2'h0) ramp_reg <= ramp_reg - 2'h1;
  end
  assign at_speed_o = (ramp_reg == 2'h3);
  assign stopped_o = (ramp_reg == 2'h0);
endmodule
`default_nettype wire

// ===== tb/tb_sbt_standby_timer.sv
`default_nettype none
module tb_sbt_standby_timer;
  import sbt_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TL = 4;
  logic clk_i = 0, reset_n_i = 0, cmd_valid_i = 0, access_i = 0;
  logic media_req_i = 0, epc_en_i = 0;
  logic [7:0] cmd_code_i = 8'h00, sect_cnt_i = 8'h00;
  wire logic spin_at_speed_i, spin_stopped_i;
  logic cmd_done_o, cmd_abort_o, media_ready_o, spin_on_o, standby_o;
  logic deep_standby_o, timer_en_o, auto_standby_o;
  int errors = 0, n_tests = 0, cnt;
  // Rows: timeout code, timer enable bit, abort bit, seconds to time.
  logic [7:0] rc [9] = '{8'h00, 8'h01, 8'h02, 8'hF0, 8'hF1, 8'hFC, 8'hFD,
    8'hFF, 8'hFE};
  logic [8:0] re = 9'h1FE, ra = 9'h100;
  int rs [9] = '{0, 5, 10, 1200, 1800, 1260, 0, 1275, 0};
  always #10 clk_i = ~clk_i;
  sbt_standby_timer #(.TICK_LEN(TL)) sbt_standby_timer_i (.clk_i,
    .reset_n_i, .cmd_valid_i, .cmd_code_i, .sect_cnt_i, .access_i,
    .media_req_i, .epc_en_i, .spin_at_speed_i, .spin_stopped_i, .cmd_done_o,
    .cmd_abort_o, .media_ready_o, .spin_on_o, .standby_o, .deep_standby_o,
    .timer_en_o, .auto_standby_o);
  sbt_motor motor_i (.clk_i, .spin_on_i(spin_on_o),
    .at_speed_o(spin_at_speed_i), .stopped_o(spin_stopped_i));
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s exp %0d got %0d", nm, exp, got);
    end
  endtask
  task automatic cmd(logic [7:0] cd, logic [7:0] sc, logic ep);
    @(negedge clk_i);
    cmd_valid_i = 1;
    cmd_code_i = cd;
    sect_cnt_i = sc;
    epc_en_i = ep;
    @(negedge clk_i);
    cmd_valid_i = 0;
  endtask
  // Spin up by a media access, then count idle cycles to auto standby.
  task automatic run_to_sleep(int mid);
    @(negedge clk_i);
    access_i = 1;
    media_req_i = 1;
    @(negedge clk_i);
    access_i = 0;
    media_req_i = 0;
    for (cnt = 0; cnt < 99 && media_ready_o !== 1'b1; cnt++) @(negedge clk_i);
    for (cnt = 0; cnt < 8000 && auto_standby_o !== 1'b1; cnt++) begin
      @(negedge clk_i);
      access_i = (cnt == mid);
    end
  endtask
  task automatic final_report;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Table rows first, then the reload, deep-standby, spin-up and reset cases.
  initial begin
    repeat (5) @(negedge clk_i);
    reset_n_i = 1;
    chk("spin_on", 1, spin_on_o);
    for (int i = 0; i < 9; i++) begin
      cmd(i[0] ? CMD_STANDBY_ALT : CMD_STANDBY, rc[i], 0);
      chk("done", !ra[i], cmd_done_o);
      chk("abort", ra[i], cmd_abort_o);
      chk("timer_en", re[i], timer_en_o);
      if (rs[i] != 0) begin
        run_to_sleep(-1);
        chk("interval", 1, cnt >= rs[i]*TL-3 && cnt <= rs[i]*TL+3);
      end
    end
    cmd(CMD_STANDBY, 8'h01, 0);
    run_to_sleep(10);
    chk("reload", 1, cnt >= 28 && cnt <= 34);
    repeat (6) @(negedge clk_i);
    cmd(CMD_STANDBY, 8'h01, 1);
    chk("standby", 1, standby_o);
    repeat (6) @(negedge clk_i);
    chk("deep", 1, deep_standby_o);
    // A command while spinning up must send the drive down at once.
    access_i = 1;
    media_req_i = 1;
    @(negedge clk_i);
    access_i = 0;
    media_req_i = 0;
    cmd(CMD_STANDBY, 8'h01, 0);
    chk("spinup_done", 1, cmd_done_o);
    chk("spinup_spin", 0, spin_on_o);
    chk("spinup_standby", 1, standby_o);
    reset_n_i = 0;
    @(negedge clk_i);
    reset_n_i = 1;
    chk("reset_standby", 0, standby_o);
    chk("reset_timer", 0, timer_en_o);
    chk("reset_spin", 1, spin_on_o);
    final_report;
  end
  // Cut a hang short well past the expected run length.
  initial begin
    #1000000;
    errors++;
    final_report;
  end
endmodule
`default_nettype wire
